// *** gpio_port_regs.svh ***
// Purpose: constants for the gpio port: field codes, reset values, widths
// Assumes: included by bare name, definitions only
// Notes:   encodings of mode, trigger and drive fields are local choices
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

`define GPIO_MAX_PINS        8
`define GPIO_MASK_W          8
`define GPIO_INDEX_W         3
`define GPIO_DATA_ADDR_W     10
`define GPIO_MASK_LSB        2
`define GPIO_MODE_RST        2'h0
`define GPIO_TRIG_RST        3'h0
`define GPIO_DRIVE_RST       2'h0
`define GPIO_PULL_RST        1'b0
`define GPIO_OD_RST          1'b0
`define GPIO_PAD_EN_RST      1'b0
`define GPIO_IRQ_EN_RST      1'b0

`endif

// *** gpio_port_pkg.sv ***
// Purpose: types shared by the gpio port files
// Assumes: nothing
// Notes:   enum codes follow declaration order
package gpio_port_pkg;
  typedef enum logic [1:0] {
    sw_input_mode,
    sw_output_mode,
    peripheral_control_mode
  } dir_mode_e;

  typedef enum logic [2:0] {
    trig_falling,
    trig_rising,
    trig_both,
    trig_low,
    trig_high
  } trig_e;

  typedef enum logic [1:0] {
    drive_2ma,
    drive_4ma,
    drive_8ma,
    drive_8ma_slew
  } drive_e;
endpackage

// *** gpio_irq_detect.sv ***
// Purpose: per-pin interrupt trigger detection with latched edge status
// Assumes: pin levels are synchronous to ref_clk
// Notes:   set wins over a clear arriving in the same cycle
`timescale 1ns/1ps
module gpio_irq_detect
  import gpio_port_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // pin side
  input  wire logic              pin_level,
  input  wire logic [2:0]        trig_sel,
  // software side
  input  wire logic              clear,
  output logic                   raw_status
);
  logic prev_level;
  logic edge_hit;
  logic edge_latch;
  logic level_mode;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      prev_level <= 1'b0;
    else
      prev_level <= pin_level;
  end

  always_comb
  begin
    case (trig_e'(trig_sel))
      trig_falling: edge_hit = prev_level & ~pin_level;
      trig_rising:  edge_hit = ~prev_level & pin_level;
      trig_both:    edge_hit = prev_level ^ pin_level;
      default:      edge_hit = 1'b0;
    endcase
    level_mode = (trig_sel == trig_low) || (trig_sel == trig_high);
  end

  // edge status sticks until cleared; a new edge beats the clear
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      edge_latch <= 1'b0;
    else if (level_mode)
      edge_latch <= 1'b0;
    else if (edge_hit)
      edge_latch <= 1'b1;
    else if (clear)
      edge_latch <= 1'b0;
  end

  // level status follows the pin while the level is present
  always_comb
  begin
    if (trig_sel == trig_low)
      raw_status = ~pin_level;
    else if (trig_sel == trig_high)
      raw_status = pin_level;
    else
      raw_status = edge_latch;
  end
endmodule

// *** gpio_port_pin_control.sv ***
// Purpose: eight-pin general purpose port with pad, mode and irq control
// Assumes: one clock, synchronous active-high reset, inputs synchronous
// Notes:   commands are one-cycle strobes carrying a pin mask
//
// What this block does
// - Controls up to eight pins; fewer via the pin count parameter.
// - After reset every pin is a software-controlled input.
// - Per pin interrupt on high, low, rising, falling or both edges.
// - Each pin holds a 2, 4 or 8 mA drive setting to pad.
// - Slew control exists only with 8 mA, a fourth drive setting.
// - Drive setting resets to the 2 mA selection.
// - Weak pull-up and pull-down per pin, both off after reset.
// - Open-drain enable per pin, off after reset: push-pull start.
// - Pin selects port or peripheral control, resets to port control.
// - Peripheral mode on a pin with no peripheral does nothing useful.
// - Masks are eight bits, bit n is pin n, only set bits act.
// - Masked read returns selected pin levels, others read zero.
// - Masked write updates all selected pins together, others untouched.
// - Data mask comes from address bits of one access.
// - Single pin addressed by an index zero to seven.
// - Mode per pin: sw input, sw output, peripheral; masked set.
// - Direction and mode of one pin can be read back.
// - Trigger type of one pin can be read back.
// - Pad path connects only after pad configuration too.
// - Configuration writes apply to all masked pins at once.
// - Per pin interrupt enable bit set or cleared by software.
// - Raw and masked eight-bit status, bit n for pin n.
// - Software clears latched interrupts of masked pins.
`timescale 1ns/1ps
`include "gpio_port_regs.svh"
module gpio_port_pin_control
  import gpio_port_pkg::*;
#(
  parameter int          PIN_COUNT     = `GPIO_MAX_PINS,
  parameter logic [7:0]  PERIPH_AVAIL  = 8'hFF
)
(
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // masked data access, mask in address bits
  input  wire logic [`GPIO_DATA_ADDR_W-1:0] data_addr,
  input  wire logic                        data_wr,
  input  wire logic [7:0]                  data_wdata,
  output logic [7:0]                       data_rdata,
  // configuration commands, one-cycle strobes
  input  wire logic [7:0]                  pin_select_mask,
  input  wire logic                        dir_mode_wr,
  input  wire logic [1:0]                  direction_mode_sel,
  input  wire logic                        trig_wr,
  input  wire logic [2:0]                  irq_trigger_sel,
  input  wire logic                        pad_wr,
  input  wire logic [1:0]                  drive_sel,
  input  wire logic                        pull_up_sel,
  input  wire logic                        pull_down_sel,
  input  wire logic                        open_drain_sel,
  input  wire logic                        irq_enable_wr,
  input  wire logic                        irq_disable_wr,
  input  wire logic                        irq_clear_wr,
  // single pin readback
  input  wire logic [`GPIO_INDEX_W-1:0]    pin_index,
  output logic [1:0]                       pin_dir_mode,
  output logic [2:0]                       pin_trig,
  output logic [1:0]                       pin_drive,
  output logic                             pin_pull_up,
  output logic                             pin_pull_down,
  output logic                             pin_open_drain,
  // interrupt status
  input  wire logic                        status_masked_sel,
  output logic [7:0]                       irq_status,
  output logic                             irq,
  // pads
  input  wire logic [7:0]                  pad_in,
  output logic [7:0]                       pad_out,
  output logic [7:0]                       pad_oe,
  output logic [1:0]                       pad_drive [8],
  output logic [7:0]                       pad_pull_up,
  output logic [7:0]                       pad_pull_down,
  // peripheral side
  input  wire logic [7:0]                  periph_out,
  input  wire logic [7:0]                  periph_oe,
  output logic [7:0]                       periph_in
);

  // refuse a pin count the eight-bit masks cannot serve
  if (PIN_COUNT < 1 || PIN_COUNT > `GPIO_MAX_PINS)
  begin : g_bad_count
    $error("pin count out of range");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  localparam logic [7:0] PRESENT = 8'((9'h001 << PIN_COUNT) - 9'h001);

  // clip a mask to the pins this instance actually has
  function automatic logic [7:0] present_mask(input logic [7:0] m);
    present_mask = m & PRESENT;
  endfunction

  // ---------------------------------------------------------------
  // per pin state
  // ---------------------------------------------------------------
  logic [1:0] mode      [8];
  logic [2:0] trig      [8];
  logic [1:0] drive     [8];
  logic [7:0] pull_up;
  logic [7:0] pull_down;
  logic [7:0] open_drain;
  logic [7:0] pad_ready;
  logic [7:0] out_data;
  logic [7:0] irq_en;
  logic [7:0] raw_stat;
  logic [7:0] cmd_mask;
  logic [7:0] data_mask;
  logic [7:0] in_level;

  assign cmd_mask  = present_mask(pin_select_mask);
  // data mask rides on address bits [9:2]
  assign data_mask = present_mask(data_addr[`GPIO_MASK_LSB +: 8]);

  // ---------------------------------------------------------------
  // mode and trigger
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (rst)
        mode[i] <= `GPIO_MODE_RST;
      else if (dir_mode_wr && cmd_mask[i] &&
               direction_mode_sel <= 2'(peripheral_control_mode))
        mode[i] <= direction_mode_sel;
    end
  end

  // inputs are assumed stable while software retunes triggers
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (rst)
        trig[i] <= `GPIO_TRIG_RST;
      else if (trig_wr && cmd_mask[i] && irq_trigger_sel <= 3'(trig_high))
        trig[i] <= irq_trigger_sel;
    end
  end

  // ---------------------------------------------------------------
  // pad configuration
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (rst)
      begin
        drive[i]      <= `GPIO_DRIVE_RST;
        pull_up[i]    <= `GPIO_PULL_RST;
        pull_down[i]  <= `GPIO_PULL_RST;
        open_drain[i] <= `GPIO_OD_RST;
        pad_ready[i]  <= `GPIO_PAD_EN_RST;
      end
      else if (pad_wr && cmd_mask[i])
      begin
        drive[i]      <= drive_sel;
        pull_up[i]    <= pull_up_sel;
        pull_down[i]  <= pull_down_sel & ~pull_up_sel;
        open_drain[i] <= open_drain_sel;
        pad_ready[i]  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // data register, masked write
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      out_data <= 8'h00;
    else if (data_wr)
      out_data <= (out_data & ~data_mask) | (data_wdata & data_mask);
  end

  // ---------------------------------------------------------------
  // pad drive path
  // ---------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      in_level[i]  = pad_in[i] & pad_ready[i] & PRESENT[i];
      periph_in[i] = (mode[i] == 2'(peripheral_control_mode)) &
                     PERIPH_AVAIL[i] & in_level[i];
      pad_out[i] = 1'b0;
      pad_oe[i]  = 1'b0;
      if (pad_ready[i] && PRESENT[i])
      begin
        if (mode[i] == 2'(sw_output_mode))
        begin
          pad_out[i] = out_data[i] & ~open_drain[i];
          pad_oe[i]  = ~open_drain[i] | ~out_data[i];
        end
        else if (mode[i] == 2'(peripheral_control_mode) && PERIPH_AVAIL[i])
        begin
          pad_out[i] = periph_out[i] & ~open_drain[i];
          pad_oe[i]  = periph_oe[i] & (~open_drain[i] | ~periph_out[i]);
        end
      end
      pad_drive[i]     = drive[i];
      pad_pull_up[i]   = pull_up[i] & pad_ready[i];
      pad_pull_down[i] = pull_down[i] & pad_ready[i];
    end
  end

  // ---------------------------------------------------------------
  // masked data read, registered
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      data_rdata <= 8'h00;
    else
      data_rdata <= in_level & data_mask;
  end

  // ---------------------------------------------------------------
  // single pin readback
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pin_dir_mode   <= `GPIO_MODE_RST;
      pin_trig       <= `GPIO_TRIG_RST;
      pin_drive      <= `GPIO_DRIVE_RST;
      pin_pull_up    <= 1'b0;
      pin_pull_down  <= 1'b0;
      pin_open_drain <= 1'b0;
    end
    else
    begin
      pin_dir_mode   <= mode[pin_index];
      pin_trig       <= trig[pin_index];
      pin_drive      <= drive[pin_index];
      pin_pull_up    <= pull_up[pin_index];
      pin_pull_down  <= pull_down[pin_index];
      pin_open_drain <= open_drain[pin_index];
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 8; g++)
  begin : g_det
    gpio_irq_detect u_det (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .pin_level  (in_level[g]),
      .trig_sel   (trig[g]),
      .clear      (irq_clear_wr & cmd_mask[g]),
      .raw_status (raw_stat[g])
    );
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irq_en <= 8'h00;
    else if (irq_enable_wr)
      irq_en <= irq_en | cmd_mask;
    else if (irq_disable_wr)
      irq_en <= irq_en & ~cmd_mask;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irq_status <= 8'h00;
    else if (status_masked_sel)
      irq_status <= raw_stat & irq_en;
    else
      irq_status <= raw_stat;
  end

  // registered so the interrupt line never glitches on mask changes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(raw_stat & irq_en);
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_write_taken;
    data_wr ##1 1'b1;
  endsequence

  a_masked_write: assert property (@(posedge ref_clk) disable iff (rst)
    s_write_taken |-> ((out_data & $past(data_mask)) ==
                       ($past(data_wdata) & $past(data_mask))) &&
                      ((out_data & ~$past(data_mask)) ==
                       ($past(out_data) & ~$past(data_mask))))
    else $error("masked write wrong");

  a_read_masked: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> (data_rdata & ~$past(data_mask)) == 8'h00)
    else $error("unselected pins visible on read");

  a_irq_or: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> irq == |($past(raw_stat) & $past(irq_en)))
    else $error("irq not or of masked status");

  a_reset_input: assert property (@(posedge ref_clk)
    rst |=> pad_oe == 8'h00 && pin_drive == 2'h0)
    else $error("pins not inputs after reset");

  a_mode_set: assert property (@(posedge ref_clk) disable iff (rst)
    dir_mode_wr && cmd_mask[0] && direction_mode_sel == 2'h1
      |=> mode[0] == 2'h1)
    else $error("mode not applied");

  a_no_pad_path: assert property (@(posedge ref_clk) disable iff (rst)
    !pad_ready[0] |-> !pad_oe[0])
    else $error("pad driven before pad setup");

  a_irq_enable: assert property (@(posedge ref_clk) disable iff (rst)
    irq_enable_wr && cmd_mask[1] |=> irq_en[1])
    else $error("irq enable not set");

  a_readback: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> pin_trig == $past(trig[pin_index]))
    else $error("trigger readback wrong");
endmodule

// *** pad_model.sv ***
// Purpose: board and pad model in front of the gpio port pins
// Assumes: one clock; the board drives a pin only where ext_en is set
// Notes:   an undriven pin with no pull toggles every cycle
`timescale 1ns/1ps
module pad_model
(
  // clock
  input  wire logic       ref_clk,
  // port side
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pull_up,
  input  wire logic [7:0] pad_pull_down,
  // board side
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pad_in
);
  logic [7:0] float_pat = 8'h55;

  // a floating pin must never settle to a value a test could trust
  always_ff @(posedge ref_clk)
    float_pat <= ~float_pat;

  always_comb
    for (int i = 0; i < 8; i++)
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_pull_up[i])
        pad_in[i] = 1'b1;
      else if (pad_pull_down[i])
        pad_in[i] = 1'b0;
      else
        pad_in[i] = float_pat[i];
endmodule

// *** gpio_port_pin_control_bench.sv ***
// Purpose: self-checking bench for the gpio port
// Assumes: inputs change 1 ns after the rising edge
// Notes:   pin 7 has no peripheral in this build
`timescale 1ns/1ps
`include "gpio_port_regs.svh"
module gpio_port_pin_control_bench
  import gpio_port_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int DIR = 0, TRG = 1, PAD = 2, IEN = 3, IDS = 4, ICL = 5;
  logic       ref_clk, rst, data_wr, dir_mode_wr, trig_wr, pad_wr;
  logic       pull_up_sel, pull_down_sel, open_drain_sel, irq;
  logic       irq_enable_wr, irq_disable_wr, irq_clear_wr;
  logic       pin_pull_up, pin_pull_down, pin_open_drain;
  logic       status_masked_sel;
  logic [9:0] data_addr;
  logic [7:0] data_wdata, data_rdata, pin_select_mask, irq_status;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
  logic [7:0] periph_out, periph_oe, periph_in, ext_val, ext_en;
  logic [2:0] irq_trigger_sel, pin_index, pin_trig;
  logic [1:0] direction_mode_sel, drive_sel, pin_dir_mode, pin_drive;
  logic [1:0] pad_drive [8];
  int         miscompares, num_checks, cycles;

  gpio_port_pin_control #(.PIN_COUNT(8), .PERIPH_AVAIL(8'h7F))
  u_gpio_port_pin_control (.*);
  pad_model u_pad_model (.ref_clk(ref_clk), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .ext_val(ext_val),
    .ext_en(ext_en), .pad_in(pad_in));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic cmd(input int k, input logic [7:0] m);
    pin_select_mask = m;
    case (k)
      DIR: dir_mode_wr = 1'b1;
      TRG: trig_wr = 1'b1;
      PAD: pad_wr = 1'b1;
      IEN: irq_enable_wr = 1'b1;
      IDS: irq_disable_wr = 1'b1;
      default: irq_clear_wr = 1'b1;
    endcase
    cyc();
    {dir_mode_wr, trig_wr, pad_wr} = 3'h0;
    {irq_enable_wr, irq_disable_wr, irq_clear_wr} = 3'h0;
    cyc();
  endtask

  task automatic wr(input logic [7:0] m, input logic [7:0] v);
    data_addr = {m, 2'b00};
    data_wdata = v;
    data_wr = 1'b1;
    cyc();
    data_wr = 1'b0;
    cyc();
  endtask

  task automatic rd(input logic [7:0] m);
    data_addr = {m, 2'b00};
    cyc(2);
  endtask

  task automatic rb(input logic [2:0] n);
    pin_index = n;
    cyc();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(pad_oe, 8'h00, "oe after reset");
    chk(pad_pull_up | pad_pull_down, 8'h00, "pulls");
    for (int n = 0; n < 8; n++)
    begin
      rb(n[2:0]);
      chk(pin_dir_mode, sw_input_mode, "mode");
      chk(pin_drive, drive_2ma, "drive");
      chk(pad_drive[n], drive_2ma, "pad drive");
      chk({pin_pull_up, pin_pull_down}, 2'h0, "pull");
      chk(pin_open_drain, 1'b0, "open drain");
    end
  endtask

  task automatic t_data();
    direction_mode_sel = 2'h1;
    cmd(DIR, 8'h09);
    chk(pad_oe, 8'h00, "oe before pad cfg");
    cmd(PAD, 8'hFF);
    chk(pad_oe, 8'h09, "oe after pad cfg");
    wr(8'h09, 8'hFF);
    chk(pad_out & 8'h09, 8'h09, "write both");
    wr(8'h01, 8'h00);
    chk(pad_out & 8'h09, 8'h08, "write one");
    wr(8'h00, 8'h00);
    chk(pad_out & 8'h09, 8'h08, "empty mask");
    rd(8'h0F);
    chk(data_rdata, 8'h0E, "read low");
    rd(8'hF0);
    chk(data_rdata, 8'hA0, "read high");
    open_drain_sel = 1'b1;
    cmd(PAD, 8'h08);
    chk(pad_oe & 8'h09, 8'h01, "od released");
    wr(8'h08, 8'h00);
    chk(pad_oe & 8'h09, 8'h09, "od low");
    open_drain_sel = 1'b0;
  endtask

  task automatic t_pad();
    for (int k = 0; k < 4; k++)
    begin
      drive_sel = k[1:0];
      pull_up_sel = (k == 1);
      pull_down_sel = (k == 2);
      open_drain_sel = k[0];
      cmd(PAD, 8'h60);
      rb(3'h5);
      chk(pin_drive, k[1:0], "drive code");
      chk(pad_drive[6], k[1:0], "pad drive code");
      chk(pad_drive[4], drive_2ma, "unmasked drive");
      chk({pin_pull_up, pin_pull_down}, {k == 1, k == 2}, "pulls");
      chk(pad_pull_down[6], k == 2, "pad pull down");
      chk(pad_pull_up[5], k == 1, "pad pull up");
      chk(pin_open_drain, k[0], "od code");
    end
    {drive_sel, pull_up_sel, pull_down_sel, open_drain_sel} = 5'h0;
  endtask

  task automatic t_irq();
    ext_val[1] = 1'b0;
    cyc(3);
    // the pin stays still while the trigger changes
    irq_trigger_sel = trig_rising;
    cmd(TRG, 8'h02);
    cmd(ICL, 8'hFF);
    cmd(IEN, 8'h02);
    cyc(2);
    chk(irq, 1'b0, "idle irq");
    ext_val[1] = 1'b1;
    cyc(3);
    chk(irq_status & 8'h02, 8'h02, "raw edge");
    chk(irq, 1'b1, "irq");
    ext_val[1] = 1'b0;
    status_masked_sel = 1'b1;
    cyc(3);
    chk(irq_status, 8'h02, "masked latched");
    cmd(IDS, 8'h02);
    cyc(2);
    chk(irq_status, 8'h00, "masked off");
    chk(irq, 1'b0, "irq masked");
    status_masked_sel = 1'b0;
    cmd(IEN, 8'h02);
    cmd(ICL, 8'h02);
    cyc(2);
    chk(irq_status & 8'h02, 8'h00, "cleared");
    chk(irq, 1'b0, "irq cleared");
    irq_trigger_sel = trig_high;
    cmd(TRG, 8'h02);
    ext_val[1] = 1'b1;
    cyc(3);
    chk(irq, 1'b1, "level high");
    ext_val[1] = 1'b0;
    cyc(3);
    chk(irq_status & 8'h02, 8'h00, "level follows");
    irq_trigger_sel = trig_low;
    cmd(TRG, 8'h02);
    cyc(2);
    chk(irq_status & 8'h02, 8'h02, "level low");
    irq_trigger_sel = trig_both;
    cmd(TRG, 8'h02);
    cmd(ICL, 8'h02);
    ext_val[1] = 1'b1;
    cyc(3);
    chk(irq_status & 8'h02, 8'h02, "both rise");
    cmd(ICL, 8'h02);
    chk(irq_status & 8'h02, 8'h00, "both cleared");
    ext_val[1] = 1'b0;
    cyc(3);
    chk(irq_status & 8'h02, 8'h02, "both fall");
    for (int k = 0; k < 6; k++)
    begin
      irq_trigger_sel = k[2:0];
      cmd(TRG, 8'h80);
      rb(3'h7);
      chk(pin_trig, (k < 5) ? k[2:0] : 3'h4, "trig code");
    end
  endtask

  task automatic t_periph();
    periph_oe = 8'hFF;
    periph_out = 8'h04;
    direction_mode_sel = 2'h2;
    cmd(DIR, 8'h84);
    chk(pad_oe & 8'h84, 8'h04, "periph drive");
    chk(pad_out & 8'h04, 8'h04, "periph out");
    chk(periph_in & 8'h04, 8'h04, "periph in");
    chk(periph_in & 8'h80, 8'h00, "no periph on pin 7");
    direction_mode_sel = 2'h3;
    cmd(DIR, 8'h04);
    rb(3'h2);
    chk(pin_dir_mode, peripheral_control_mode, "refused mode");
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // the tests need well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial
  begin
    rst = 1'b1;
    {data_wr, dir_mode_wr, trig_wr, pad_wr, status_masked_sel} = 5'h0;
    {pull_up_sel, pull_down_sel, open_drain_sel} = 3'h0;
    {irq_enable_wr, irq_disable_wr, irq_clear_wr} = 3'h0;
    {data_addr, data_wdata, pin_select_mask} = 26'h0;
    {direction_mode_sel, drive_sel, irq_trigger_sel, pin_index} = 10'h0;
    {periph_out, periph_oe} = 16'h0;
    ext_val = 8'hA6;
    ext_en = 8'hF6;
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_data();
    t_pad();
    t_irq();
    t_periph();
    tally_and_finish();
  end
endmodule
